// File: design/dis_line_gen.v
// line type generator with its line counter
`timescale 1ns/1ps
`include "dis_map.vh"
module dis_line_gen (
  input wire aclk,
  input wire aresetn,
  input wire preset_line,
  input wire down_count_clk,
  input wire vector_intensify_flag,
  input wire line_type_bit_low,
  input wire line_type_bit_high,
  output reg line_on_r
);
  reg [3:0] line_count_r;
  reg half_r;
  wire line_counter_bit_four;
  wire line_counter_bit_three;
  reg line_nxt;

  assign line_counter_bit_four = line_count_r[3];
  assign line_counter_bit_three = line_count_r[2];

  // divide the down-count strobe by two, then count down
  always @(posedge aclk) begin
    if (!aresetn) begin
      line_count_r <= `DIS_LC_PRESET;
      half_r <= 1'b0;
    end else if (preset_line) begin
      line_count_r <= `DIS_LC_PRESET; // [RQ18]
      half_r <= 1'b0;
    end else if (down_count_clk) begin
      half_r <= ~half_r;
      if (half_r)
        line_count_r <= line_count_r - 4'h1; // [RQ18]
    end
  end

  // the both-set code is not documented here; treated as solid
  always @* begin
    case ({line_type_bit_high, line_type_bit_low})
      2'b01: line_nxt = line_counter_bit_four; // [RQ17]
      2'b10: line_nxt = line_counter_bit_three; // [RQ17]
      default: line_nxt = 1'b1; // [RQ17]
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn)
      line_on_r <= 1'b0;
    else
      line_on_r <= vector_intensify_flag & line_nxt; // [RQ16]
  end
endmodule

// File: design/dis_map.vh
// constants for the display instruction sequencer
// Function
// [RQ1] four pulses per fetched word
// [RQ2] 11100 in bits 15:11 decodes jump
// [RQ3] jump second word becomes next address
// [RQ4] jump first word latches control mode
// [RQ5] bit 15 word clears second-word flag
// [RQ6] add two at tp1, request at tp2
// [RQ7] set second-word flag after jump fetch
// [RQ8] second word blocks mode reload and clear
// [RQ9] second word loads counter, skips increment
// [RQ10] clear second-word flag after target fetch
// [RQ11] 11101 is no-op, only advances
// [RQ12] 10 in bits 15:14 selects graphic mode
// [RQ13] graphic mode captures data mode bits
// [RQ14] load pulse updates flags and intensity
// [RQ15] data word clears control-word flag
// [RQ16] line decoder gated by vector intensify
// [RQ17] line flags select solid, long, short
// [RQ18] line counter preset fifteen, half rate
// [RQ19] bits 3,4 set or reset blink
// [RQ20] intensity loads when bit 10 set
// [RQ21] counter and modes stable between fetches
`ifndef DIS_MAP_VH
`define DIS_MAP_VH
`define DIS_OP_JUMP 5'h1c
`define DIS_OP_NOOP 5'h1d
`define DIS_PC_RESET 16'h0000
`define DIS_PC_STEP 16'h0002
`define DIS_LC_PRESET 4'hf
`define DIS_INT_RESET 3'h0
`define DIS_CMODE_GRAPHIC 3'h0
// register offsets on the control bus
`define DIS_REG_CTRL 4'h0
`define DIS_REG_PC 4'h4
`define DIS_REG_STAT 4'h8
`define DIS_REG_WORD 4'hc
// control register fields
`define DIS_CTRL_RUN 0
`define DIS_CTRL_VEC 1
`define DIS_CTRL_START 2
`define DIS_CTRL_DNCLK 3
`define DIS_CTRL_LDLC 4
`endif

// File: design/dis_sequencer.v
// instruction sequencer top with axi4-lite control and fetch port
`timescale 1ns/1ps
`include "dis_map.vh"
module dis_sequencer (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg memory_read_request,
  output reg [15:0] fetch_addr_r,
  input wire fetch_data_ready,
  input wire [15:0] fetch_data,
  output reg [6:0] data_mode_sel_r,
  output reg graphic_mode_decoded,
  output reg noop_decoded,
  output reg line_on_out_r
);
  // timing states, one-hot
  localparam ST_IDLE = 5'h01;
  localparam ST_MODE = 5'h02;
  localparam ST_LOAD = 5'h04;
  localparam ST_TP1 = 5'h08;
  localparam ST_TP2 = 5'h10;

  reg [4:0] state_r;
  reg [15:0] word_r;
  reg [15:0] display_program_counter;
  reg [2:0] ctrl_mode_r;
  reg [2:0] data_mode_r;
  reg control_word_flag;
  reg second_word_flag;
  reg jump_decoded;
  reg line_type_bit_low;
  reg line_type_bit_high;
  reg blink_enable_flag;
  reg pen_interrupt_enable_flag;
  reg [2:0] intensity_r;
  reg [4:0] ctrl_r;
  reg aw_held_r;
  reg w_held_r;
  reg [3:0] awaddr_r;
  reg [31:0] wdata_r;
  wire line_on;
  wire jump_second_word_active;
  wire mode_latch_pulse;
  wire operand_load_pulse;
  wire first_timing_pulse;
  wire second_timing_pulse;
  wire is_instr;
  wire do_write;
  wire advance_pc_by_two;
  wire jump_target_load;
  wire clear_second_word;

  // opcode field of a word
  function [4:0] op_of;
    input [15:0] w;
    begin
      op_of = w[15:11];
    end
  endfunction

  // one-hot select for a 3-bit mode code
  function [6:0] mode_onehot;
    input [2:0] m;
    begin
      mode_onehot = 7'h00;
      if (m != 3'h0)
        mode_onehot[m - 3'h1] = 1'b1;
    end
  endfunction

  assign mode_latch_pulse = (state_r == ST_MODE);
  assign operand_load_pulse = (state_r == ST_LOAD);
  assign first_timing_pulse = (state_r == ST_TP1);
  assign second_timing_pulse = (state_r == ST_TP2);
  assign jump_second_word_active = second_word_flag & jump_decoded; // [RQ8]
  assign is_instr = word_r[15];
  assign clear_second_word = mode_latch_pulse & is_instr
    & ~jump_second_word_active; // [RQ5] [RQ8]
  assign jump_target_load = operand_load_pulse & jump_second_word_active;
  assign advance_pc_by_two = first_timing_pulse & ~jump_second_word_active;

  ////////////////////////////////////////////////////////////////////////
  // four-pulse timing sequence per fetched word
  always @(posedge aclk) begin
    if (!aresetn)
      state_r <= ST_IDLE;
    else begin
      case (state_r)
        ST_IDLE: if (fetch_data_ready) state_r <= ST_MODE; // [RQ1]
        ST_MODE: state_r <= ST_LOAD; // [RQ1]
        ST_LOAD: state_r <= ST_TP1; // [RQ1]
        ST_TP1: state_r <= ST_TP2; // [RQ1]
        ST_TP2: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // capture the fetched word as the data arrives
  always @(posedge aclk) begin
    if (!aresetn)
      word_r <= 16'h0000;
    else if (state_r == ST_IDLE && fetch_data_ready)
      word_r <= fetch_data;
  end

  ////////////////////////////////////////////////////////////////////////
  // mode decode at load-mode; held otherwise so fetches stay coherent
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_mode_r <= `DIS_CMODE_GRAPHIC;
      data_mode_r <= 3'h0;
      control_word_flag <= 1'b0;
      jump_decoded <= 1'b0;
      noop_decoded <= 1'b0;
      graphic_mode_decoded <= 1'b0;
      data_mode_sel_r <= 7'h00;
    end else if (mode_latch_pulse && !jump_second_word_active) begin // [RQ8]
      jump_decoded <= 1'b0;
      noop_decoded <= 1'b0;
      if (is_instr && !word_r[14]) begin
        ctrl_mode_r <= `DIS_CMODE_GRAPHIC; // [RQ12]
        control_word_flag <= 1'b1; // [RQ12]
        graphic_mode_decoded <= 1'b1; // [RQ12]
        data_mode_r <= word_r[13:11]; // [RQ13]
        data_mode_sel_r <= 7'h00; // [RQ13]
      end else if (is_instr) begin
        ctrl_mode_r <= word_r[13:11]; // [RQ4]
        control_word_flag <= 1'b1;
        graphic_mode_decoded <= 1'b0;
        data_mode_sel_r <= 7'h00;
        jump_decoded <= (op_of(word_r) == `DIS_OP_JUMP); // [RQ2] [RQ4]
        noop_decoded <= (op_of(word_r) == `DIS_OP_NOOP); // [RQ11]
      end else begin
        control_word_flag <= 1'b0; // [RQ15]
        graphic_mode_decoded <= 1'b0; // [RQ15]
        data_mode_sel_r <= mode_onehot(data_mode_r); // [RQ15]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // second-word flag: set after the jump's first word, cleared after target
  always @(posedge aclk) begin
    if (!aresetn)
      second_word_flag <= 1'b0;
    else if (clear_second_word)
      second_word_flag <= 1'b0; // [RQ5]
    else if (second_timing_pulse && jump_second_word_active)
      second_word_flag <= 1'b0; // [RQ10]
    else if (second_timing_pulse && jump_decoded)
      second_word_flag <= 1'b1; // [RQ7]
  end

  ////////////////////////////////////////////////////////////////////////
  // program counter, fetch request and software start
  always @(posedge aclk) begin
    if (!aresetn) begin
      display_program_counter <= `DIS_PC_RESET;
      memory_read_request <= 1'b0;
      fetch_addr_r <= `DIS_PC_RESET;
    end else begin
      memory_read_request <= 1'b0;
      if (do_write && awaddr_r == `DIS_REG_PC)
        display_program_counter <= {wdata_r[15:1], 1'b0}; // [RQ21]
      else if (jump_target_load)
        display_program_counter <= {word_r[15:1], 1'b0}; // [RQ3] [RQ9]
      else if (advance_pc_by_two)
        display_program_counter <= display_program_counter
          + `DIS_PC_STEP; // [RQ6] [RQ11]
      // request rides on tp2 so the freshly updated counter is used
      if (second_timing_pulse && ctrl_r[`DIS_CTRL_RUN]) begin
        memory_read_request <= 1'b1; // [RQ6] [RQ9]
        fetch_addr_r <= display_program_counter; // [RQ21]
      end else if (do_write && awaddr_r == `DIS_REG_CTRL
          && wdata_r[`DIS_CTRL_START]) begin
        memory_read_request <= 1'b1;
        fetch_addr_r <= display_program_counter;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // display parameters loaded at load-pulse of graphic mode
  always @(posedge aclk) begin
    if (!aresetn) begin
      line_type_bit_low <= 1'b0;
      line_type_bit_high <= 1'b0;
      blink_enable_flag <= 1'b0;
      pen_interrupt_enable_flag <= 1'b0;
      intensity_r <= `DIS_INT_RESET;
    end else if (operand_load_pulse && graphic_mode_decoded) begin
      if (word_r[2]) begin // [RQ14]
        line_type_bit_low <= word_r[0];
        line_type_bit_high <= word_r[1];
      end
      if (word_r[4])
        blink_enable_flag <= 1'b1; // [RQ19]
      else if (word_r[3])
        blink_enable_flag <= 1'b0; // [RQ19]
      if (word_r[6])
        pen_interrupt_enable_flag <= word_r[5]; // [RQ14]
      if (word_r[10])
        intensity_r <= word_r[9:7]; // [RQ20]
    end
  end

  dis_line_gen u_line (
    .aclk(aclk),
    .aresetn(aresetn),
    .preset_line(do_write && awaddr_r == `DIS_REG_CTRL
      && wdata_r[`DIS_CTRL_LDLC]),
    .down_count_clk(ctrl_r[`DIS_CTRL_DNCLK]),
    .vector_intensify_flag(ctrl_r[`DIS_CTRL_VEC]),
    .line_type_bit_low(line_type_bit_low),
    .line_type_bit_high(line_type_bit_high),
    .line_on_r(line_on)
  );

  always @(posedge aclk) begin
    if (!aresetn)
      line_on_out_r <= 1'b0;
    else
      line_on_out_r <= line_on;
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write: address and data in either order, then response
  assign do_write = aw_held_r & w_held_r & ~s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h00000000;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      ctrl_r <= 5'h00;
    end else begin
      s_axi_awready <= ~aw_held_r & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_held_r & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awready && s_axi_awvalid) begin
        aw_held_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr[3:2], 2'h0};
      end
      if (s_axi_wready && s_axi_wvalid) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wstrb[0] ? s_axi_wdata : 32'h00000000;
      end
      // strobe bits self-clear so they act as one-cycle pulses
      ctrl_r[`DIS_CTRL_START] <= 1'b0;
      ctrl_r[`DIS_CTRL_DNCLK] <= 1'b0;
      ctrl_r[`DIS_CTRL_LDLC] <= 1'b0;
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_r == `DIS_REG_CTRL
          || awaddr_r == `DIS_REG_PC) ? 2'h0 : 2'h2;
        if (awaddr_r == `DIS_REG_CTRL)
          ctrl_r <= wdata_r[4:0];
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
      end
    end
  end

  // axi4-lite read: one cycle to accept, data the next
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case ({s_axi_araddr[3:2], 2'h0})
          `DIS_REG_CTRL: s_axi_rdata <= {27'h0, ctrl_r};
          `DIS_REG_PC: s_axi_rdata <= {16'h0, display_program_counter};
          `DIS_REG_STAT: s_axi_rdata <= {15'h0000, data_mode_r, ctrl_mode_r,
            intensity_r, pen_interrupt_enable_flag, blink_enable_flag,
            line_type_bit_high, line_type_bit_low, jump_decoded,
            second_word_flag, control_word_flag, state_r[0]};
          `DIS_REG_WORD: s_axi_rdata <= {16'h0, word_r};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// File: testbench/dis_mem_model.sv
// core memory model answering each fetch request after a random wait
`timescale 1ns/1ps
module dis_mem_model (
  input wire aclk,
  input wire aresetn,
  input wire memory_read_request,
  input wire [15:0] fetch_addr_r,
  output logic fetch_data_ready,
  output logic [15:0] fetch_data
);
  logic [15:0] mem [0:127];
  logic [15:0] word_r;
  logic pend_r;
  int wait_r;
  // idle bus shows the inverted word so a stale value never matches
  always @(posedge aclk) begin
    fetch_data_ready <= 1'b0;
    fetch_data <= ~word_r;
    if (!aresetn) begin
      pend_r <= 1'b0;
      word_r <= 16'h0000;
    end else if (memory_read_request) begin
      pend_r <= 1'b1;
      wait_r <= $urandom_range(3, 0);
      word_r <= mem[fetch_addr_r[7:1]];
    end else if (pend_r && wait_r == 0) begin
      pend_r <= 1'b0;
      fetch_data_ready <= 1'b1;
      fetch_data <= word_r;
    end else if (pend_r) begin
      wait_r <= wait_r - 1;
    end
  end
endmodule

// File: testbench/dis_seq_asserts.sv
// concurrent checks on the sequencer fetch port and mode decode outputs
`timescale 1ns/1ps
module dis_seq_asserts (
  input wire aclk,
  input wire aresetn,
  input wire memory_read_request,
  input wire [15:0] fetch_addr_r,
  input wire fetch_data_ready,
  input wire [6:0] data_mode_sel_r,
  input wire graphic_mode_decoded,
  input wire noop_decoded
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  //////////////////////////////////////////////////////////////////////////
  // decodes may only move two or three edges after a word is taken
  a_decode_timed: assert property (
    $changed({graphic_mode_decoded, noop_decoded, data_mode_sel_r}) |->
    $past(fetch_data_ready, 2) || $past(fetch_data_ready, 3) ||
    !$past(aresetn))
    else $error("decode outputs moved without a fetched word");
  a_req_pulse: assert property (
    memory_read_request |=> !memory_read_request)
    else $error("fetch request longer than one cycle");
  // no new fetch while the four timing pulses run
  a_req_quiet: assert property (
    fetch_data_ready |=> !memory_read_request [*4])
    else $error("fetch request inside the timing pulses");
  a_mode_onehot: assert property (
    $onehot0(data_mode_sel_r))
    else $error("more than one data mode selected");
  a_graphic_excl: assert property (
    graphic_mode_decoded |-> data_mode_sel_r == 7'h00)
    else $error("data mode shown while control mode drives the decoder");
  a_noop_excl: assert property (
    noop_decoded |-> !graphic_mode_decoded)
    else $error("no-op and graphic mode decoded together");
  a_addr_even: assert property (
    memory_read_request |-> fetch_addr_r[0] == 1'b0)
    else $error("odd fetch address");
  // the address only moves together with a request, never in between
  a_addr_held: assert property (
    $changed(fetch_addr_r) |-> memory_read_request || !$past(aresetn))
    else $error("fetch address changed between requests");
  c_graphic: cover property (graphic_mode_decoded);
  c_noop: cover property (noop_decoded);
  c_data: cover property (data_mode_sel_r != 7'h00);
endmodule

bind dis_sequencer dis_seq_asserts u_chk (.aclk(aclk), .aresetn(aresetn),
  .memory_read_request(memory_read_request), .fetch_addr_r(fetch_addr_r),
  .fetch_data_ready(fetch_data_ready), .data_mode_sel_r(data_mode_sel_r),
  .graphic_mode_decoded(graphic_mode_decoded), .noop_decoded(noop_decoded));

// File: testbench/display_instruction_sequencer_tb_top.sv
// self-checking bench for the display instruction sequencer
`timescale 1ns/1ps
module display_instruction_sequencer_tb_top;
  logic aclk, aresetn, awv, awr, wv, wr, bv, brd, arv, arr, rv, rrd;
  logic req, fdr, gm, nop, lon;
  logic [3:0] awa, ara;
  logic [31:0] wd, rd, d, p1;
  logic [1:0] br, rr, r;
  logic [15:0] fa, fd;
  logic [6:0] sel;
  int errors, samples_checked, cycles, e, i, m1, m2, pi, pen;
  int qa[$], qd[$];

  dis_sequencer u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brd),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rrd), .memory_read_request(req), .fetch_addr_r(fa),
    .fetch_data_ready(fdr), .fetch_data(fd), .data_mode_sel_r(sel),
    .graphic_mode_decoded(gm), .noop_decoded(nop), .line_on_out_r(lon));
  dis_mem_model u_mem (.aclk(aclk), .aresetn(aresetn),
    .memory_read_request(req), .fetch_addr_r(fa), .fetch_data_ready(fdr),
    .fetch_data(fd));
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checked=%0d errors=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // address and data offered together, bready held until bvalid seen
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
    awa <= a;
    wd <= v;
    {awv, wv, brd} <= 3'h7;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      if (bv) begin
        brd <= 1'b0;
        r = br;
      end
    end while (brd);
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] v,
                        output logic [1:0] s);
    ara <= a;
    {arv, rrd} <= 2'h3;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
      if (rv) begin
        rrd <= 1'b0;
        v = rd;
        s = rr;
      end
    end while (rrd);
  endtask
  // expectation: fetch address, then {check sel, sel, graphic, no-op}
  task automatic exp_fetch(input int a, input int c);
    qa.push_back(a);
    qd.push_back(c);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // hang guard, the whole run needs well under a thousand cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      give_verdict();
    end
  end
  // each request is compared with the next expected fetch in qa until the queue runs empty
  always @(posedge aclk) begin
    if (req === 1'b1 && qa.size() > 0) begin
      e = qd.pop_front();
      check(fa, qa.pop_front());
      check({gm, nop}, e[1:0]);
      if (e[9]) check(sel, e[8:2]);
    end
  end
  initial begin
    void'($urandom(32'h8180580c));
    aresetn = 1'b0;
    {awv, wv, brd, arv, rrd} = 5'h00;
    awa = 4'h0;
    ara = 4'h0;
    wd = 32'h0;
    m1 = $urandom_range(7, 1);
    m2 = $urandom_range(7, 1);
    pi = $urandom_range(7, 0);
    pen = $urandom_range(1, 0);
    p1 = $urandom;
    // graphic, data, no-op, jump, then graphic, data and a jump to itself
    u_mem.mem[0] = {2'b10, m1[2:0], p1[10:0]};
    u_mem.mem[1] = {1'b0, p1[14:0]};
    u_mem.mem[2] = {5'h1d, p1[26:16]};
    u_mem.mem[3] = {5'h1c, p1[10:0]};
    u_mem.mem[4] = 16'h0041;
    u_mem.mem[32] = {2'b10, m2[2:0], 1'b1, pi[2:0], 1'b1, pen[0], 5'h15};
    u_mem.mem[33] = {1'b0, p1[31:17]};
    u_mem.mem[34] = 16'he000;
    u_mem.mem[35] = 16'h0044;
    exp_fetch(0, 10'h200);
    exp_fetch(2, 10'h202);
    exp_fetch(4, 10'h200 | (2 << m1));
    exp_fetch(6, 1);
    exp_fetch(8, 0);
    exp_fetch(64, 0);
    exp_fetch(66, 10'h202);
    exp_fetch(68, 10'h200 | (2 << m2));
    exp_fetch(70, 0);
    exp_fetch(68, 0);
    exp_fetch(70, 0);
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_wr(4'h4, 32'h13);
    axi_rd(4'h4, d, r);
    check(d, 32'h12);
    // only bits 3:2 pick the word, so offset 2 reads the control word
    axi_rd(4'h2, d, r);
    check(r, 2'h0);
    // status is read-only: a write there is refused with slave error
    axi_wr(4'h8, 32'h0);
    check(r, 2'h2);
    axi_wr(4'h4, 32'h0);
    axi_wr(4'h0, 32'h5);
    while (qa.size() > 0) @(posedge aclk);
    axi_wr(4'h0, 32'h0);
    repeat (20) @(posedge aclk);
    axi_rd(4'h8, d, r);
    check(d & 32'h1c7f0, (m2 << 14) | (pi << 8) | (pen << 7) | 32'h50);
    // long dash: preset shows bit three, eight half-rate steps clear it
    axi_wr(4'h0, 32'h12);
    repeat (3) @(posedge aclk);
    check(lon, 1);
    for (i = 0; i < 16; i++) begin
      axi_wr(4'h0, 32'h0a);
      if (i == 13) begin
        repeat (3) @(posedge aclk);
        check(lon, 1);
      end
    end
    repeat (3) @(posedge aclk);
    check(lon, 0);
    axi_wr(4'h0, 32'h12);
    axi_wr(4'h0, 32'h00);
    repeat (3) @(posedge aclk);
    check(lon, 0);
    // short dash: one graphic word fetched by hand while run stays off
    u_mem.mem[40] = {2'b10, m1[2:0], 11'h006};
    axi_wr(4'h4, 32'h50);
    axi_wr(4'h0, 32'h04);
    repeat (20) @(posedge aclk);
    axi_wr(4'h0, 32'h12);
    repeat (3) @(posedge aclk);
    check(lon, 1);
    // four half-rate steps take the counter to eleven, bit two clear
    for (i = 0; i < 8; i++) begin
      axi_wr(4'h0, 32'h0a);
    end
    repeat (3) @(posedge aclk);
    check(lon, 0);
    give_verdict();
  end
endmodule
